/* rtl/qaw_pkg.sv */
// Shared constants, types and helpers of the question-answer watchdog
package qaw_pkg;

  // Clock period of the block's own clock
  localparam int CLK_PERIOD_NS = 25;

  // Error count values
  localparam logic [2:0] EC_INIT = 3'h6;
  localparam logic [2:0] EC_MAX = 3'h7;
  localparam logic [2:0] ALARM_MIN = 3'h5;
  localparam logic [2:0] CNT_MAX = 3'h7;

  // Answer byte index, waits for byte three after a run
  localparam logic [1:0] IDX_RST = 2'h3;
  localparam logic [1:0] IDX_LAST = 2'h0;

  // Cycle timing, counted in watchdog clock ticks
  localparam logic [13:0] WIN_TICKS = 14'h0040;
  localparam logic [13:0] DLY_UNIT_TICKS = 14'h0040;

  // Reset output pulse width
  localparam int RST_HOLD_NS = 500;
  localparam logic [4:0] RST_HOLD_CYC =
    5'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Question generator reset values and wrap point
  localparam logic [3:0] QCNT_RST = 4'h0;
  localparam logic [3:0] CHAIN_RST = 4'h0;
  localparam logic [3:0] QCNT_TOP = 4'hF;

  // Monitoring cycle phase
  typedef enum logic {QAW_WAIT, QAW_WIN} qaw_phase_t;

  // State of the main watchdog module
  typedef struct packed {
    logic [1:0] wsync;
    logic wprev;
    logic [1:0] uvsync;
    qaw_phase_t phase;
    logic [13:0] timer;
    logic [7:0] delay;
    logic [1:0] idx;
    logic bad;
    logic [2:0] error_count;
    logic [2:0] rst_cnt;
    logic [2:0] abort_cnt;
    logic abort;
    logic flag;
    logic [4:0] hold;
    logic last_ok;
  } qaw_state_t;

  localparam qaw_state_t QAW_RESET = '{
    wsync: 2'h0, wprev: 1'b0, uvsync: 2'h0, phase: QAW_WAIT,
    timer: 14'h0000, delay: 8'h00, idx: IDX_RST, bad: 1'b0,
    error_count: EC_INIT, rst_cnt: 3'h0, abort_cnt: 3'h0, abort: 1'b0,
    flag: 1'b0, hold: 5'h00, last_ok: 1'b0};

  // State of the question generator
  typedef struct packed {
    logic [3:0] cnt;
    logic [3:0] chain;
    logic [3:0] question;
  } qaw_qstate_t;

  // Question bits from counter and feedback chain
  function automatic logic [3:0] qaw_question(input logic [3:0] cnt,
                                              input logic [3:0] chain);
    qaw_question = {chain[2] ^ cnt[2], chain[0] ^ cnt[0],
                    chain[3] ^ cnt[3], chain[1] ^ cnt[1]};
  endfunction

  // Expected answer byte for a question and byte index
  function automatic logic [7:0] qaw_exp_byte(input logic [3:0] q,
                                              input logic [1:0] idx);
    qaw_exp_byte = {q ^ {2'h0, idx}, ~q};
  endfunction

  // Wait ticks from the response delay setting
  function automatic logic [13:0] qaw_wait_ticks(input logic [7:0] d);
    qaw_wait_ticks = 14'({6'h00, d} * DLY_UNIT_TICKS);
  endfunction

endpackage

/* rtl/qaw_qgen_if.sv */
// Link between the watchdog core and its question generator
interface qaw_qgen_if;
  logic step;
  logic clear;
  logic [3:0] question;
  modport gen (input step, input clear, output question);
  modport user (output step, output clear, input question);
endinterface

/* rtl/qaw_question_gen.sv */
// Question generator: 4-bit counter plus 4-bit feedback chain
module qaw_question_gen
  import qaw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Core link
  qaw_qgen_if.gen qbus
);

  qaw_qstate_t st_reg;
  qaw_qstate_t st_next;
  logic fb;

  // Step counter on correct answers; chain moves only on counter wrap
  always_comb begin
    st_next = st_reg;
    fb = (st_reg.chain[3] ^ st_reg.chain[2]) | (st_reg.chain == 4'h0);
    if (qbus.clear) begin
      st_next.cnt = QCNT_RST;
      st_next.chain = CHAIN_RST;
    end else if (qbus.step) begin
      st_next.cnt = st_reg.cnt + 4'h1;
      if (st_reg.cnt == QCNT_TOP) begin
        st_next.chain = {st_reg.chain[2:0], fb};
      end
    end
    st_next.question = qaw_question(st_next.cnt, st_next.chain);
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '{cnt: QCNT_RST, chain: CHAIN_RST, question: 4'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign qbus.question = st_reg.question;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_clear_zero;
    qbus.clear |=> (st_reg.cnt == 4'h0) && (st_reg.chain == 4'h0);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("question state not zero after undervoltage");

  property p_hold;
    !qbus.step && !qbus.clear |=> $stable(st_reg.cnt) && $stable(st_reg.chain);
  endproperty
  a_hold: assert property (p_hold)
    else $error("question moved without a correct answer");

  property p_count_step;
    qbus.step && !qbus.clear |=> st_reg.cnt == 4'($past(st_reg.cnt) + 4'h1);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("question counter did not advance");

  property p_chain_wrap;
    qbus.step && !qbus.clear && (st_reg.cnt != QCNT_TOP) |=> $stable(st_reg.chain);
  endproperty
  a_chain_wrap: assert property (p_chain_wrap)
    else $error("feedback chain stepped without counter wrap");

endmodule

/* rtl/qaw_watchdog.sv */
// Question-answer watchdog core: timing, answer check, error counting
// Behaviour
// - Question readable; host fetches before answering
// - Byte zero or delay write starts cycle
// - Cycle is wait time then window, repeats
// - Good timely answer, nonzero delay: count down
// - Bad, late or zero-delay answer: count up
// - Only byte zero completion must hit window
// - Same question until answered right and timely
// - Error count is three bits, selects actions
// - Error count starts at six, reloads
// - Count above four drives alarm output
// - Overflow resets only when reset enabled
// - Reset event also drives alarm pin low
// - Reset counter stops resets at seven
// - Abort counter counts overflows, overflow at seven ends afterrun
// - Abort counter clears below five or undervoltage
// - Result and next question readable after byte zero
// - Question counter advances only on success
// - Chain steps on counter wrap after success
// - Delay write or expiry keeps question
// - Undervoltage forces counter and chain zero
// - Chain feedback bit3 xor bit2, zero escape
// - Question bits mix chain and counter bits
// - Byte index selects expected byte, starts three
// - Reset enable clear means no overflow reset
// - Reset flag set on reset, cleared on read
module qaw_watchdog
  import qaw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pins from other domains
  input wire logic watchdog_clock,
  input wire logic undervoltage_reset,
  // Host answer and delay writes
  input wire logic answer_wr,
  input wire logic [7:0] answer_data,
  input wire logic delay_wr,
  input wire logic [7:0] delay_data,
  // Host configuration and flag read
  input wire logic reset_on_overflow_enable,
  input wire logic flag_rd,
  // Readable state
  output logic [3:0] question_low_reg,
  output logic [3:0] question_high_reg,
  output logic [7:0] response_delay_reg,
  output logic [2:0] reset_count,
  output logic monitor_reset_flag,
  // Protective outputs
  output logic internal_alarm_level,
  output logic algorithmic_watchdog_alarm_o,
  output logic algorithmic_watchdog_alarm_oe,
  output logic monitor_reset_request,
  output logic afterrun_abort
);

  qaw_state_t st_reg;
  qaw_state_t st_next;
  qaw_qgen_if qif ();

  logic wtick;
  logic uv_act;
  logic restart;
  logic ans_done;
  logic cyc_ok;
  logic cyc_err;
  logic ovf;

  // Question generator; cleared while undervoltage is seen
  qaw_question_gen u_qgen (
    .clk(clk),
    .srst(srst),
    .qbus(qif)
  );

  assign qif.step = cyc_ok & ~uv_act;
  assign qif.clear = uv_act;

  // Next-state logic of the whole watchdog
  always_comb begin
    st_next = st_reg;
    restart = 1'b0;
    ans_done = 1'b0;
    cyc_ok = 1'b0;
    cyc_err = 1'b0;
    ovf = 1'b0;
    // Two-flop synchronisers, edges taken from the second stage only
    st_next.wsync = {st_reg.wsync[0], watchdog_clock};
    st_next.wprev = st_reg.wsync[1];
    st_next.uvsync = {st_reg.uvsync[0], undervoltage_reset};
    wtick = st_reg.wsync[1] & ~st_reg.wprev;
    uv_act = st_reg.uvsync[1];
    // Reset pulse width counter
    if (st_reg.hold != 5'h00) begin
      st_next.hold = st_reg.hold - 5'h01;
    end
    // Read clears the flag; a set below in the same cycle wins
    if (flag_rd) begin
      st_next.flag = 1'b0;
    end
    // Wait then window, counted in watchdog ticks
    if (wtick) begin
      if (st_reg.timer != 14'h0000) begin
        st_next.timer = st_reg.timer - 14'h0001;
      end else if (st_reg.phase == QAW_WAIT) begin
        st_next.phase = QAW_WIN;
        st_next.timer = WIN_TICKS - 14'h0001;
      end else begin
        // No complete answer inside the window counts as an error
        cyc_err = 1'b1;
        restart = 1'b1;
      end
    end
    // Byte-wise compare against the expected answer
    if (answer_wr) begin
      st_next.bad = st_reg.bad |
        (answer_data != qaw_exp_byte(question_low_reg, st_reg.idx));
      st_next.idx = st_reg.idx - 2'h1;
      if (st_reg.idx == IDX_LAST) begin
        ans_done = 1'b1;
        restart = 1'b1;
        // Only the last byte is held to the window
        cyc_ok = ~st_next.bad && (st_reg.phase == QAW_WIN) &&
                 (st_reg.delay != 8'h00);
        cyc_err = ~cyc_ok;
        st_next.last_ok = cyc_ok;
      end
    end
    // Delay write restarts the cycle but keeps the question
    if (delay_wr) begin
      st_next.delay = delay_data;
      restart = 1'b1;
    end
    // Sequencer run: back to the wait phase, fresh compare
    if (restart) begin
      st_next.phase = QAW_WAIT;
      st_next.timer = qaw_wait_ticks(st_next.delay);
      st_next.idx = IDX_RST;
      st_next.bad = 1'b0;
    end
    // Error count up or down, overflow reloads six
    if (cyc_ok && (st_reg.error_count != 3'h0)) begin
      st_next.error_count = st_reg.error_count - 3'h1;
    end
    if (cyc_err) begin
      if (st_reg.error_count == EC_MAX) begin
        ovf = 1'b1;
        st_next.error_count = EC_INIT;
      end else begin
        st_next.error_count = st_reg.error_count + 3'h1;
      end
    end
    // Overflow consequences
    if (ovf) begin
      if (st_reg.abort_cnt == CNT_MAX) begin
        st_next.abort = 1'b1;
      end else begin
        st_next.abort_cnt = st_reg.abort_cnt + 3'h1;
      end
      if (reset_on_overflow_enable && (st_reg.rst_cnt != CNT_MAX)) begin
        st_next.rst_cnt = st_reg.rst_cnt + 3'h1;
        st_next.hold = RST_HOLD_CYC;
        st_next.flag = 1'b1;
      end
    end
    // Abort state clears with the alarm low, or on undervoltage below
    if (st_reg.error_count < ALARM_MIN) begin
      st_next.abort_cnt = 3'h0;
      st_next.abort = 1'b0;
    end
    // Undervoltage returns everything but the synchronisers to reset
    if (uv_act) begin
      st_next = QAW_RESET;
      st_next.wsync = {st_reg.wsync[0], watchdog_clock};
      st_next.wprev = st_reg.wsync[1];
      st_next.uvsync = {st_reg.uvsync[0], undervoltage_reset};
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= QAW_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Readable registers
  assign question_low_reg = qif.question;
  assign question_high_reg = {st_reg.last_ok, st_reg.error_count};
  assign response_delay_reg = st_reg.delay;
  assign reset_count = st_reg.rst_cnt;
  assign monitor_reset_flag = st_reg.flag;

  // Protective outputs; the open-drain alarm pin only ever pulls low
  assign internal_alarm_level = st_reg.error_count >= ALARM_MIN;
  assign monitor_reset_request = st_reg.hold != 5'h00;
  assign algorithmic_watchdog_alarm_o = 1'b0;
  assign algorithmic_watchdog_alarm_oe =
    internal_alarm_level | monitor_reset_request;
  assign afterrun_abort = st_reg.abort;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_overflow;
    cyc_err && (st_reg.error_count == EC_MAX) && !uv_act;
  endsequence

  sequence s_reset_pulse;
    monitor_reset_request [*8];
  endsequence

  property p_ec_start;
    $fell(srst) |-> st_reg.error_count == EC_INIT;
  endproperty
  a_ec_start: assert property (p_ec_start)
    else $error("error count not six after reset");

  property p_ec_down;
    cyc_ok && !uv_act && (st_reg.error_count != 3'h0) |=>
      st_reg.error_count == 3'($past(st_reg.error_count) - 3'h1);
  endproperty
  a_ec_down: assert property (p_ec_down)
    else $error("error count did not decrement");

  property p_ec_up;
    cyc_err && !uv_act && (st_reg.error_count != EC_MAX) |=>
      st_reg.error_count == 3'($past(st_reg.error_count) + 3'h1);
  endproperty
  a_ec_up: assert property (p_ec_up)
    else $error("error count did not increment");

  property p_ovf_reload;
    s_overflow |=> st_reg.error_count == EC_INIT;
  endproperty
  a_ovf_reload: assert property (p_ovf_reload)
    else $error("overflow did not reload six");

  property p_ovf_reset;
    s_overflow ##0 (reset_on_overflow_enable && st_reg.rst_cnt != CNT_MAX) |=>
      s_reset_pulse ##0 monitor_reset_flag;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset)
    else $error("enabled overflow gave no reset pulse");

  property p_no_reset_disabled;
    s_overflow ##0 !reset_on_overflow_enable && !monitor_reset_request |=>
      !monitor_reset_request && $stable(st_reg.rst_cnt);
  endproperty
  a_no_reset_disabled: assert property (p_no_reset_disabled)
    else $error("reset generated while disabled");

  property p_reset_limit;
    s_overflow ##0 (st_reg.rst_cnt == CNT_MAX) && !monitor_reset_request |=>
      !monitor_reset_request && (st_reg.rst_cnt == CNT_MAX);
  endproperty
  a_reset_limit: assert property (p_reset_limit)
    else $error("reset beyond the limit");

  property p_alarm_on_reset;
    monitor_reset_request |-> algorithmic_watchdog_alarm_oe;
  endproperty
  a_alarm_on_reset: assert property (p_alarm_on_reset)
    else $error("alarm pin not low during reset");

  property p_abort_set;
    s_overflow ##0 (st_reg.abort_cnt == CNT_MAX) |=> afterrun_abort;
  endproperty
  a_abort_set: assert property (p_abort_set)
    else $error("afterrun abort not raised");

  property p_abort_clear;
    st_reg.error_count < ALARM_MIN |=> (st_reg.abort_cnt == 3'h0) && !afterrun_abort;
  endproperty
  a_abort_clear: assert property (p_abort_clear)
    else $error("abort counter not cleared with alarm low");

  property p_index_restart;
    ans_done |=> st_reg.idx == IDX_RST && !st_reg.bad && st_reg.phase == QAW_WAIT;
  endproperty
  a_index_restart: assert property (p_index_restart)
    else $error("answer did not restart the cycle");

  property p_zero_delay;
    ans_done && (st_reg.delay == 8'h00) |-> cyc_err;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("zero delay answer not an error");

  // Delay writes and expiries must never move the question on
  property p_step_on_answer;
    qif.step |-> ans_done && (st_reg.phase == QAW_WIN) && (st_reg.delay != 8'h00);
  endproperty
  a_step_on_answer: assert property (p_step_on_answer)
    else $error("question stepped without a timely answer");

  // A read in the overflow cycle must not hide the new reset
  property p_flag_set_wins;
    $rose(monitor_reset_request) |-> monitor_reset_flag;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("reset flag missing at reset pulse start");

endmodule

/* test/qaw_host_model.sv */
// Host side model: fetches the question, then writes the four answer bytes
module qaw_host_model (
  // Clock
  input wire logic clk,
  // Question shown by the watchdog
  input wire logic [3:0] question,
  // Answer byte writes
  output logic answer_wr,
  output logic [7:0] answer_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    answer_wr = 1'b0;
    answer_data = 8'h00;
  end

  // Bytes go back to back; mask spoils byte two when a wrong answer is wanted
  task automatic send(input logic [7:0] mask);
    logic [3:0] q;
    q = question;
    for (int k = 3; k >= 0; k--) begin
      @(negedge clk);
      answer_wr = 1'b1;
      answer_data = {q ^ {2'h0, 2'(k)}, ~q} ^ ((k == 2) ? mask : 8'h00);
    end
    @(negedge clk);
    answer_wr = 1'b0;
    // Released data must not look like a stale valid byte
    answer_data = ~answer_data;
  endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench of the question-answer watchdog
module tb_top
  import qaw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, srst, watchdog_clock, undervoltage_reset, answer_wr, delay_wr, flag_rd;
  logic reset_on_overflow_enable, monitor_reset_flag, internal_alarm_level, alarm_o, alarm_oe;
  logic monitor_reset_request, afterrun_abort, mon_en;
  logic [7:0] answer_data, delay_data, response_delay_reg, prev_seen;
  logic [3:0] question_low_reg, question_high_reg, cnt, chain;
  logic [2:0] reset_count, ec;
  logic [7:0] exp_q[$];
  int err_count, tests_run, cycles, req_cycles, oe_gaps;

  qaw_watchdog i_dut (.clk(clk), .srst(srst), .watchdog_clock(watchdog_clock),
    .undervoltage_reset(undervoltage_reset), .answer_wr(answer_wr),
    .answer_data(answer_data), .delay_wr(delay_wr), .delay_data(delay_data),
    .reset_on_overflow_enable(reset_on_overflow_enable), .flag_rd(flag_rd),
    .question_low_reg(question_low_reg), .question_high_reg(question_high_reg),
    .response_delay_reg(response_delay_reg), .reset_count(reset_count),
    .monitor_reset_flag(monitor_reset_flag), .internal_alarm_level(internal_alarm_level),
    .algorithmic_watchdog_alarm_o(alarm_o), .algorithmic_watchdog_alarm_oe(alarm_oe),
    .monitor_reset_request(monitor_reset_request), .afterrun_abort(afterrun_abort));

  qaw_host_model i_host (.clk(clk), .question(question_low_reg), .answer_wr(answer_wr),
    .answer_data(answer_data));

  // Block clock and free-running tick clock of unrelated phase
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    watchdog_clock = 1'b0;
    #37;
    forever #100 watchdog_clock = ~watchdog_clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Own question mixing of counter and chain
  function automatic logic [3:0] qfun(input logic [3:0] z, input logic [3:0] m);
    qfun = {m[2] ^ z[2], m[0] ^ z[0], m[3] ^ z[3], m[1] ^ z[1]};
  endfunction

  // Note the expected result of one answer or expiry
  task automatic note(input logic good);
    if (good) begin
      if (ec != 3'h0)
        ec = ec - 3'h1;
      cnt = cnt + 4'h1;
      if (cnt == 4'h0)
        chain = {chain[2:0], (chain[3] ^ chain[2]) | (chain == 4'h0)};
    end else begin
      ec = (ec == EC_MAX) ? EC_INIT : ec + 3'h1;
    end
    exp_q.push_back({good, ec, qfun(cnt, chain)});
  endtask

  task automatic answer(input logic good, input logic [7:0] mask);
    note(good);
    i_host.send(mask);
    repeat (8) @(negedge clk);
  endtask

  task automatic write_delay(input logic [7:0] d);
    @(negedge clk);
    delay_data = d;
    delay_wr = 1'b1;
    @(negedge clk);
    delay_wr = 1'b0;
  endtask

  // Wait a random time that lands inside the window of a delay-one cycle
  task automatic wait_window();
    repeat (600 + $urandom_range(0, 299)) @(negedge clk);
  endtask

  // Result watcher: errors move the count, good answers move the question
  initial begin
    prev_seen = 8'h60;
    forever begin
      @(negedge clk);
      if (mon_en && {question_high_reg, question_low_reg} !== prev_seen) begin
        repeat (2) @(negedge clk);
        if (exp_q.size() == 0) begin
          err_count++;
          $display("Error at %0t: seen %h expected %h", $time, question_high_reg, 4'h0);
        end else begin
          check({question_high_reg, question_low_reg}, exp_q.pop_front());
        end
      end
      prev_seen = {question_high_reg, question_low_reg};
    end
  end

  // Reset pulse length and alarm pin drive during it; hang guard
  always @(negedge clk) begin
    cycles++;
    if (monitor_reset_request) begin
      req_cycles++;
      if (alarm_oe !== 1'b1)
        oe_gaps++;
    end
    if (cycles == 30000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(54));
    {srst, undervoltage_reset, delay_wr, flag_rd, mon_en} = 5'h10;
    reset_on_overflow_enable = 1'b1;
    delay_data = 8'h00;
    {ec, cnt, chain} = {EC_INIT, 8'h00};
    repeat (16) @(negedge clk);
    srst = 1'b0;
    check({question_high_reg, question_low_reg}, 8'h60);
    check({7'h00, internal_alarm_level & alarm_oe}, 8'h01);
    mon_en = 1'b1;
    // Zero delay: correct answers still count up, the second overflows
    write_delay(8'h00);
    repeat (40) @(negedge clk);
    answer(1'b0, 8'h00);
    answer(1'b0, 8'h00);
    repeat (30) @(negedge clk);
    check(8'(req_cycles), 8'(RST_HOLD_CYC));
    check(8'(oe_gaps), 8'h00);
    check({5'h00, reset_count}, 8'h01);
    check({7'h00, monitor_reset_flag}, 8'h01);
    @(negedge clk);
    flag_rd = 1'b1;
    @(negedge clk);
    flag_rd = 1'b0;
    check({7'h00, monitor_reset_flag}, 8'h00);
    // Overflow with reset generation disabled
    reset_on_overflow_enable = 1'b0;
    for (int i = 0; i < 2; i++) begin
      answer(1'b0, 8'h00);
      repeat (32) @(negedge clk);
    end
    check(8'(req_cycles), 8'(RST_HOLD_CYC));
    check({5'h00, reset_count}, 8'h01);
    // Delay one: timely answer, then an early one inside the wait
    write_delay(8'h01);
    check(response_delay_reg, 8'h01);
    wait_window();
    answer(1'b1, 8'h00);
    repeat (10) @(negedge clk);
    answer(1'b0, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wait_window();
      answer(1'b1, 8'h00);
    end
    check({6'h00, internal_alarm_level, alarm_oe}, 8'h00);
    wait_window();
    answer(1'b0, 8'h01 | 8'($urandom()));
    check({7'h00, internal_alarm_level}, 8'h01);
    // No answer: the window runs out and the question stays
    note(1'b0);
    repeat (1300) @(negedge clk);
    // Sixteen early answers: eight overflows, resets up to the limit, afterrun ends
    reset_on_overflow_enable = 1'b1;
    for (int i = 0; i < 16; i++) begin
      answer(1'b0, 8'h00);
    end
    check(8'(req_cycles), 8'(7 * RST_HOLD_CYC));
    check({5'h00, reset_count}, 8'h07);
    check({7'h00, afterrun_abort}, 8'h01);
    check({7'h00, monitor_reset_flag}, 8'h01);
    check({7'h00, alarm_o}, 8'h00);
    // Thirteen good answers wrap the counter and step the chain once
    for (int i = 0; i < 13; i++) begin
      wait_window();
      answer(1'b1, 8'h00);
    end
    check({7'h00, afterrun_abort}, 8'h00);
    mon_en = 1'b0;
    check(8'(exp_q.size()), 8'h00);
    undervoltage_reset = 1'b1;
    repeat (10) @(negedge clk);
    check({question_high_reg, question_low_reg}, 8'h60);
    check({4'h0, reset_count, afterrun_abort}, 8'h00);
    undervoltage_reset = 1'b0;
    end_of_test();
  end
endmodule
